// file: hdl/part_consts.svh
// Register offsets, field positions and reset values of the auto-reload PWM timer.
// Assumes byte-wide registers on a plain strobe port with an 8-bit address.
`ifndef PART_CONSTS_SVH
`define PART_CONSTS_SVH

// Register offsets.
`define PART_OFF_DUTY1 8'h14
`define PART_OFF_DUTY0 8'h15
`define PART_OFF_PWM_CONTROL_REG 8'h16
`define PART_OFF_CSR 8'h17
`define PART_OFF_CAR 8'h18
`define PART_OFF_ARR 8'h19
`define PART_OFF_CAPTURE_CONTROL_STATUS 8'h1A
`define PART_OFF_ICR1 8'h1B
`define PART_OFF_ICR2 8'h1C

// Control and status field positions.
`define PART_CSR_EXT_CLOCK_SELECT 7
`define PART_CSR_CC_HI 6
`define PART_CSR_CC_LO 4
`define PART_CSR_TCE 3
`define PART_CSR_FORCE_RELOAD_BIT 2
`define PART_CSR_OIE 1
`define PART_CSR_OVF 0

// PWM control field positions.
`define PART_PWM_OE_LO 4
`define PART_PWM_OP_LO 0

// Capture control field positions.
`define PART_IC_CS_LO 4
`define PART_IC_CIE_LO 2
`define PART_IC_CF_LO 0

// Reset values and limits.
`define PART_RST_BYTE 8'h00
`define PART_CNT_MAX 8'hFF
`define PART_PRE_RST 7'h00

`endif

// file: hdl/part_pkg.sv
// Types shared by the auto-reload PWM timer.
// Assumes the constants header is included by the design files.
`default_nettype none
package part_pkg;
	typedef logic [7:0] part_byte_t;
	typedef logic [1:0] part_pair_t;
endpackage
`default_nettype wire

// file: hdl/part_timer.sv
// Auto-reload 8-bit PWM timer with prescaler, two PWM channels and two input captures.
// Assumes external pins are asynchronous and pass two flip-flops; halt_mode is on-clock.
//
// Overview of operation
// R1: Counter increments on each prescaler output tick.
// R2: Overflow reloads counter; prescaler untouched.
// R3: Counter readable and writable while running.
// R4: Prescaler divides by two to the select.
// R5: External clock select picks CPU or pin.
// R6: Count enable clear freezes prescaler and counter.
// R7: Reset clears counter, prescaler, clock select.
// R8: Force reload or counter write clears prescaler; force reload acts only when TCE is written set with it.
// R9: Compare shadow loads from duty at overflow.
// R10: Output enable drives pin push-pull.
// R11: Shared period is 256 minus reload.
// R12: Overflow sets polarity level; compare restores.
// R13: Software keeps compare above reload value.
// R14: PWM generation stops during halt.
// R15: Overflow sets flag and enabled interrupt.
// R16: External events counted until overflow flag.
// R17: Halt with external clock freezes control, counts.
// R18: Selected capture edge latches counter, sets flag.
// R19: Capture blocked until status register read.
// R20: Capture interrupt while flag and enable set.
// R21: Halt inhibits capture but edges still wake.
// R22: Capture interrupts align to counter clock edge.
// R23: Reading control status clears overflow flag.
// R24: Duty all ones low, zero high.
`include "part_consts.svh"
`default_nettype none
module part_timer
(
	input  wire logic               clock,
	input  wire logic               rst_b,
	input  wire logic [7:0]         addr,
	input  wire logic [7:0]         wdata,
	input  wire logic               wr_stb,
	input  wire logic               rd_stb,
	output logic [7:0]              rdata,
	input  wire logic               halt_mode,
	input  wire logic               external_clock_input,
	input  wire logic [1:0]         capture_pin,
	output logic [1:0]              pwm_pin,
	output logic [1:0]              pwm_pin_oe,
	output logic                    ovf_irq,
	output logic [1:0]              capture_irq,
	output logic                    wake_req
);

	// Two-stage synchronisers for all pin inputs.
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic       ext_prev_q;
	logic [1:0] cap_prev_q;

	// Software-visible state and the internal shadows, prescaler and pending edges.
	logic [7:0] csr_q;
	logic [7:0] arr_q;
	logic [7:0] pwm_control_reg_q;
	logic [7:0] capture_control_status_q;
	part_pkg::part_byte_t duty_q [2];
	part_pkg::part_byte_t shadow_q [2];
	part_pkg::part_byte_t icr_q [2];
	logic [7:0] cnt_q;
	logic [6:0] pre_q;
	logic [1:0] pend_q;

	// Decoded control and ticks.
	logic       ext_clock_select;
	logic       count_enable_bit;
	logic [2:0] cc;
	logic       in_tick;
	logic       cnt_tick;
	logic       ovf;
	logic       ctl_frozen;
	logic       wr_csr;
	logic       wr_car;
	logic       force_rl;
	logic       rd_csr;
	logic       rd_capture_control_status;
	logic [1:0] cap_edge;
	logic [7:0] rd_d;
	logic [1:0] pwm_d;

	// Matches the byte address against one register offset.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	// Synchroniser chain; logic reads the second stage and the edge-detect copy after it.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			sync1_q    <= 3'h0;
			sync2_q    <= 3'h0;
			ext_prev_q <= 1'b0;
			cap_prev_q <= 2'h0;
		end
		else
		begin
			sync1_q    <= {capture_pin, external_clock_input};
			sync2_q    <= sync1_q;
			ext_prev_q <= sync2_q[0];
			cap_prev_q <= sync2_q[2:1];
		end
	end

	assign ext_clock_select     = csr_q[`PART_CSR_EXT_CLOCK_SELECT];
	assign count_enable_bit      = csr_q[`PART_CSR_TCE];
	assign cc       = csr_q[`PART_CSR_CC_HI:`PART_CSR_CC_LO];
	// Input tick is every CPU clock, or a rising edge of the external clock.
	assign in_tick  = ext_clock_select ? (sync2_q[0] & ~ext_prev_q) : 1'b1; // R5
	// Counter tick when the selected prescaler tap wraps from all ones.
	assign cnt_tick = count_enable_bit & in_tick & ((pre_q & ((7'h01 << cc) - 7'h01)) == ((7'h01 << cc) - 7'h01)); // R4 R6
	assign ovf      = cnt_tick & (cnt_q == `PART_CNT_MAX);
	// Halt freezes control registers; the counter only runs on the external clock.
	// Software should clear the count enable before halting, or the external clock
	// keeps counting and may overflow into a wake request nobody expected.
	assign ctl_frozen = halt_mode; // R17
	assign wr_csr   = wr_stb & hit(addr, `PART_OFF_CSR) & ~ctl_frozen;
	assign wr_car   = wr_stb & hit(addr, `PART_OFF_CAR) & ~ctl_frozen;
	assign force_rl = wr_csr & wdata[`PART_CSR_FORCE_RELOAD_BIT] & wdata[`PART_CSR_TCE]; // R8
	assign rd_csr   = rd_stb & hit(addr, `PART_OFF_CSR);
	assign rd_capture_control_status = rd_stb & hit(addr, `PART_OFF_CAPTURE_CONTROL_STATUS);
	// Edge per channel: rising when the select bit is set, falling otherwise.
	assign cap_edge[0] = capture_control_status_q[`PART_IC_CS_LO] ? (sync2_q[1] & ~cap_prev_q[0])
		: (~sync2_q[1] & cap_prev_q[0]); // R18
	assign cap_edge[1] = capture_control_status_q[`PART_IC_CS_LO + 1] ? (sync2_q[2] & ~cap_prev_q[1])
		: (~sync2_q[2] & cap_prev_q[1]); // R18

	// Prescaler; a forced reload or counter write restarts it from zero.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			pre_q <= `PART_PRE_RST; // R7
		else if (force_rl || wr_car)
			pre_q <= `PART_PRE_RST; // R8
		else if (halt_mode && !ext_clock_select)
			pre_q <= pre_q;
		else if (count_enable_bit && in_tick)
			pre_q <= pre_q + 7'h01; // R6
	end

	// Counter with auto reload; overflow leaves the prescaler alone.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			cnt_q <= `PART_RST_BYTE; // R7
		else if (force_rl)
			cnt_q <= arr_q; // R8
		else if (wr_car)
			cnt_q <= wdata; // R3
		else if (halt_mode && !ext_clock_select)
			cnt_q <= cnt_q;
		else if (ovf)
			cnt_q <= arr_q; // R2 R11 R16
		else if (cnt_tick)
			cnt_q <= cnt_q + 8'h01; // R1
	end

	// Control and status; the overflow flag set beats a clearing read.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			csr_q <= `PART_RST_BYTE; // R7
		else
		begin
			if (wr_csr)
			begin
				csr_q[7:1] <= wdata[7:1];
				csr_q[`PART_CSR_FORCE_RELOAD_BIT] <= 1'b0;
			end
			if (ovf)
				csr_q[`PART_CSR_OVF] <= 1'b1; // R15 R16
			else if (rd_csr)
				csr_q[`PART_CSR_OVF] <= 1'b0; // R23
		end
	end

	// Plain writable registers, frozen while halted.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			arr_q     <= `PART_RST_BYTE;
			pwm_control_reg_q   <= `PART_RST_BYTE;
			duty_q[0] <= `PART_RST_BYTE;
			duty_q[1] <= `PART_RST_BYTE;
		end
		else if (wr_stb && !ctl_frozen)
		begin
			if (hit(addr, `PART_OFF_ARR))
				arr_q <= wdata;
			else if (hit(addr, `PART_OFF_PWM_CONTROL_REG))
				pwm_control_reg_q <= wdata & 8'h33;
			else if (hit(addr, `PART_OFF_DUTY0))
				duty_q[0] <= wdata;
			else if (hit(addr, `PART_OFF_DUTY1))
				duty_q[1] <= wdata;
		end
	end

	// Compare shadows follow the duty registers only at overflow.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			shadow_q[0] <= `PART_RST_BYTE;
			shadow_q[1] <= `PART_RST_BYTE;
		end
		else if (ovf)
		begin
			shadow_q[0] <= duty_q[0]; // R9
			shadow_q[1] <= duty_q[1]; // R9
		end
	end

	// Raw PWM level: active from overflow until the compare match.
	// Duty zero stays active and all ones inactive, before polarity.
	always_comb
	begin
		pwm_d = 2'h0;
		for (int i = 0; i < 2; i++)
		begin
			if (shadow_q[i] == `PART_CNT_MAX)
				pwm_d[i] = pwm_control_reg_q[`PART_PWM_OP_LO + i]; // R24
			else if (shadow_q[i] == `PART_RST_BYTE)
				pwm_d[i] = ~pwm_control_reg_q[`PART_PWM_OP_LO + i]; // R24
			else if (cnt_q <= shadow_q[i])
				pwm_d[i] = ~pwm_control_reg_q[`PART_PWM_OP_LO + i]; // R12
			else
				pwm_d[i] = pwm_control_reg_q[`PART_PWM_OP_LO + i]; // R12
		end
	end

	// Pin outputs; halt stops generation and holds the pins at their last level.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			pwm_pin    <= 2'h0;
			pwm_pin_oe <= 2'h0;
		end
		else
		begin
			pwm_pin_oe <= pwm_control_reg_q[`PART_PWM_OE_LO +: 2]; // R10
			if (!halt_mode)
				pwm_pin <= pwm_d; // R14
		end
	end

	// Capture control, flags and values; a flag blocks its register until read.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			capture_control_status_q  <= `PART_RST_BYTE;
			icr_q[0] <= `PART_RST_BYTE;
			icr_q[1] <= `PART_RST_BYTE;
			pend_q   <= 2'h0;
		end
		else
		begin
			if (wr_stb && !ctl_frozen && hit(addr, `PART_OFF_CAPTURE_CONTROL_STATUS))
				capture_control_status_q[5:2] <= wdata[5:2];
			for (int i = 0; i < 2; i++)
			begin
				// Edges wait here until the next counter clock tick, or one clock while halted.
				if (cap_edge[i])
					pend_q[i] <= 1'b1; // R22
				else if (cnt_tick || halt_mode)
					pend_q[i] <= 1'b0;
				if (pend_q[i] && (cnt_tick || halt_mode))
				begin
					if (!capture_control_status_q[`PART_IC_CF_LO + i] && !halt_mode)
						icr_q[i] <= cnt_q; // R18 R19 R21
					capture_control_status_q[`PART_IC_CF_LO + i] <= 1'b1; // R18 R21
				end
				else if (rd_capture_control_status)
					capture_control_status_q[`PART_IC_CF_LO + i] <= 1'b0; // R19
			end
		end
	end

	// Interrupt and wake levels, registered.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			ovf_irq     <= 1'b0;
			capture_irq <= 2'h0;
			wake_req    <= 1'b0;
		end
		else
		begin
			ovf_irq     <= csr_q[`PART_CSR_OVF] & csr_q[`PART_CSR_OIE]; // R15
			capture_irq <= capture_control_status_q[1:0] & capture_control_status_q[3:2]; // R20
			wake_req    <= halt_mode & ((csr_q[`PART_CSR_OVF] & csr_q[`PART_CSR_OIE])
				| (|(capture_control_status_q[1:0] & capture_control_status_q[3:2]))); // R17 R21
		end
	end

	// Read mux; force reload always reads as zero.
	// Unmapped addresses read as zero so a stray access never shows stale state.
	always_comb
	begin
		rd_d = `PART_RST_BYTE;
		if (hit(addr, `PART_OFF_CSR))
			rd_d = csr_q & 8'hFB;
		else if (hit(addr, `PART_OFF_CAR))
			rd_d = cnt_q; // R3
		else if (hit(addr, `PART_OFF_ARR))
			rd_d = arr_q;
		else if (hit(addr, `PART_OFF_PWM_CONTROL_REG))
			rd_d = pwm_control_reg_q;
		else if (hit(addr, `PART_OFF_DUTY0))
			rd_d = duty_q[0];
		else if (hit(addr, `PART_OFF_DUTY1))
			rd_d = duty_q[1];
		else if (hit(addr, `PART_OFF_CAPTURE_CONTROL_STATUS))
			rd_d = capture_control_status_q;
		else if (hit(addr, `PART_OFF_ICR1))
			rd_d = icr_q[0];
		else if (hit(addr, `PART_OFF_ICR2))
			rd_d = icr_q[1];
	end

	// Read data stand one cycle after the strobe.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
			rdata <= `PART_RST_BYTE;
		else if (rd_stb)
			rdata <= rd_d;
		else
			rdata <= `PART_RST_BYTE;
	end

endmodule
`default_nettype wire

// file: tb/part_pins.sv
// Pin-side model: external event clock and the two capture pins.
// Assumes the bench asks for levels; every pin is driven from time zero.
`default_nettype none
module part_pins
#(
	parameter int HALF = 3
)
(
	input  wire logic       clock,
	input  wire logic       ext_run,
	input  wire logic [1:0] cap_lvl,
	output logic            external_clock_input = 1'b0,
	output logic [1:0]      capture_pin = 2'b00
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	// The event clock idles low between bursts, so no stray edge is counted.
	always @(posedge clock)
	begin
		capture_pin <= cap_lvl;
		cnt <= (ext_run && cnt < 2 * HALF - 1) ? cnt + 1 : 0;
		external_clock_input <= ext_run && cnt >= HALF;
	end
endmodule
`default_nettype wire

// file: tb/part_timer_asserts.sv
// Port checker for the auto-reload PWM timer.
// Assumes it is bound to part_timer; one clock, synchronous active-low reset.
`include "part_consts.svh"
`default_nettype none
module part_timer_asserts
(
	input wire logic       clock,
	input wire logic       rst_b,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr_stb,
	input wire logic       rd_stb,
	input wire logic [7:0] rdata,
	input wire logic       halt_mode,
	input wire logic [1:0] pwm_pin,
	input wire logic [1:0] pwm_pin_oe,
	input wire logic       ovf_irq,
	input wire logic [1:0] capture_irq,
	input wire logic       wake_req
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (!rst_b);
	logic [7:0] csr_q;
	logic [7:0] pwm_q;
	logic [7:0] ic_q;
	// Mirror of the control bytes; halt drops writes, so the mirror does too.
	always_ff @(posedge clock)
	begin
		if (!rst_b)
		begin
			csr_q <= 8'h00;
			pwm_q <= 8'h00;
			ic_q <= 8'h00;
		end
		else if (wr_stb && !halt_mode)
		begin
			if (addr == `PART_OFF_CSR)
				csr_q <= wdata;
			if (addr == `PART_OFF_PWM_CONTROL_REG)
				pwm_q <= wdata;
			if (addr == `PART_OFF_CAPTURE_CONTROL_STATUS)
				ic_q <= wdata;
		end
	end
	sequence frozen_rd_s;
		rd_stb && addr == `PART_OFF_CAR && !csr_q[3];
	endsequence
	freeze_hold_a: assert property (frozen_rd_s ##2 frozen_rd_s |=> rdata == $past(rdata, 2))
		else $error("counter moved while disabled");
	oe_follow_a: assert property ($stable(pwm_q[5:4]) |-> pwm_pin_oe == pwm_q[5:4])
		else $error("output enable off its bit");
	ovf_mask_a: assert property (!csr_q[1] && !$past(csr_q[1]) |-> !ovf_irq)
		else $error("overflow irq while masked");
	cap_mask_a: assert property ((capture_irq & ~ic_q[3:2] & ~$past(ic_q[3:2])) == 2'b00)
		else $error("capture irq while masked");
	wake_halt_a: assert property (wake_req |-> $past(halt_mode))
		else $error("wake outside halt");
	pwm_hold_a: assert property (halt_mode [*3] |-> $stable(pwm_pin))
		else $error("pwm moved in halt");
	csr_back_a: assert property (rd_stb && addr == `PART_OFF_CSR |=>
		rdata[7:1] == {$past(csr_q[7:3]), 1'b0, $past(csr_q[1])})
		else $error("control byte read wrong");
	pwm_control_reg_back_a: assert property (rd_stb && addr == `PART_OFF_PWM_CONTROL_REG |=>
		rdata == ($past(pwm_q) & 8'h33))
		else $error("pwm control read wrong");
endmodule
`default_nettype wire

// file: tb/tb_part_timer.sv
// Self-checking bench for the auto-reload PWM timer.
// Assumes part_timer, its checker and the pin model are compiled first.
`include "part_consts.svh"
`default_nettype none
module tb_part_timer;
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v, r, d;
	logic       clock = 1'b0, rst_b = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0;
	logic       halt_mode = 1'b0, ext_run = 1'b0, ovf_irq, wake_req;
	logic [1:0] cap_lvl = 2'b00, pwm_pin, pwm_pin_oe, capture_irq;
	wire logic [1:0] cap_pin;
	wire logic  ext_clk;
	int         mismatches = 0, num_checks = 0, hi, h1;
	always #25 clock = ~clock;
	part_pins pins (.clock(clock), .ext_run(ext_run), .cap_lvl(cap_lvl),
		.external_clock_input(ext_clk), .capture_pin(cap_pin));
	part_timer dut (.clock(clock), .rst_b(rst_b), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .halt_mode(halt_mode),
		.external_clock_input(ext_clk), .capture_pin(cap_pin), .pwm_pin(pwm_pin),
		.pwm_pin_oe(pwm_pin_oe), .ovf_irq(ovf_irq), .capture_irq(capture_irq),
		.wake_req(wake_req));
	// The write strobe stays up at the end of a write, so back-to-back writes assign once.
	task automatic tick(int n);
		wr_stb <= 1'b0;
		rd_stb <= 1'b0;
		repeat (n) @(posedge clock);
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] x);
		addr <= a;
		wdata <= x;
		wr_stb <= 1'b1;
		rd_stb <= 1'b0;
		@(posedge clock);
	endtask
	// The strobe lasts one cycle; read data stand only in the next cycle, taken mid-cycle.
	task automatic rd(logic [7:0] a);
		addr <= a;
		rd_stb <= 1'b1;
		wr_stb <= 1'b0;
		@(posedge clock);
		rd_stb <= 1'b0;
		@(negedge clock);
		v = rdata;
		@(posedge clock);
	endtask
	task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// High cycles in one period; all-ones and zero duty pin the level.
	function automatic logic [7:0] highs(logic [7:0] dv, logic [7:0] rv, logic op);
		logic [8:0] n;
		logic [8:0] h;
		n = 9'h100 - rv;
		h = (dv == 8'hFF) ? 9'h000 : (dv == 8'h00) ? n : 9'(dv - rv + 8'h01);
		return op ? 8'(n - h) : 8'(h);
	endfunction
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// A hang ends the run through the same verdict.
	initial
	begin
		repeat (20000) @(posedge clock);
		mismatches++;
		give_verdict();
	end
	initial
	begin
		void'($urandom(32'hd3c8_6717));
		tick(10);
		rst_b <= 1'b1;
		tick(1);
		for (int a = 8'h14; a <= 8'h1C; a++)
		begin
			rd(8'(a));
			check("reset value", v, 8'h00);
		end
		rd(`PART_OFF_CAR);
		check("frozen count", v, 8'h00);
		rd(`PART_OFF_CAR);
		check("frozen count", v, 8'h00);
		$display("reset test done");
		for (int cc = 0; cc < 8; cc++)
		begin
			r = 8'($urandom_range(239));
			wr(`PART_OFF_ARR, r);
			wr(`PART_OFF_CSR, 8'(cc << 4) | 8'h0C);
			tick((7 << cc) / 2);
			rd(`PART_OFF_CAR);
			check("count", v, r + 8'h03);
		end
		$display("prescaler test done");
		wr(`PART_OFF_CSR, 8'h0A);
		wr(`PART_OFF_CAR, 8'hFE);
		tick(4);
		check("ovf irq", {7'h00, ovf_irq}, 8'h01);
		rd(`PART_OFF_CSR);
		check("ovf set", v & 8'h01, 8'h01);
		rd(`PART_OFF_CSR);
		check("ovf clear", v & 8'h01, 8'h00);
		rd(`PART_OFF_CAR);
		check("reload", v, r + 8'h06);
		$display("overflow test done");
		for (int p = 0; p < 2; p++)
		begin
			r = 8'($urandom_range(127, 1));
			d = r + 8'($urandom_range(120, 1));
			wr(`PART_OFF_ARR, r);
			wr(`PART_OFF_DUTY0, d);
			wr(`PART_OFF_DUTY1, p ? 8'h00 : 8'hFF);
			wr(`PART_OFF_PWM_CONTROL_REG, 8'h30 | 8'(p));
			wr(`PART_OFF_CSR, 8'h0C);
			tick(300);
			hi = 0;
			h1 = 0;
			repeat (256 - int'(r))
			begin
				@(posedge clock);
				hi += int'(pwm_pin[0]);
				h1 += int'(pwm_pin[1]);
			end
			check("ch0 high", 8'(hi), highs(d, r, p[0]));
			check("ch1 high", 8'(h1), highs(p ? 8'h00 : 8'hFF, r, 1'b0));
			check("oe", {6'h00, pwm_pin_oe}, 8'h03);
		end
		$display("pwm test done");
		wr(`PART_OFF_CAPTURE_CONTROL_STATUS, 8'h1C);
		cap_lvl <= 2'b11;
		tick(8);
		check("cap irq", {6'h00, capture_irq}, 8'h01);
		rd(`PART_OFF_ICR1);
		r = v;
		cap_lvl <= 2'b00;
		tick(6);
		cap_lvl <= 2'b01;
		tick(8);
		rd(`PART_OFF_ICR1);
		check("cap held", v, r);
		rd(`PART_OFF_CAPTURE_CONTROL_STATUS);
		check("cap flags", v, 8'h1F);
		tick(4);
		check("cap irq off", {6'h00, capture_irq}, 8'h00);
		$display("capture test done");
		wr(`PART_OFF_ARR, 8'hFC);
		wr(`PART_OFF_CSR, 8'h8E);
		rd(`PART_OFF_CSR);
		halt_mode <= 1'b1;
		ext_run <= 1'b1;
		wr(`PART_OFF_PWM_CONTROL_REG, 8'h00);
		tick(1);
		hi = 0;
		while (wake_req !== 1'b1 && hi < 200)
		begin
			@(posedge clock);
			hi++;
		end
		check("wake", {7'h00, wake_req}, 8'h01);
		check("events", {7'h00, hi > 21}, 8'h01);
		halt_mode <= 1'b0;
		ext_run <= 1'b0;
		rd(`PART_OFF_PWM_CONTROL_REG);
		check("frozen ctl", v, 8'h31);
		$display("halt test done");
		tick(1);
		give_verdict();
	end
endmodule
bind part_timer part_timer_asserts chk (.clock(clock), .rst_b(rst_b), .addr(addr),
	.wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
	.halt_mode(halt_mode), .pwm_pin(pwm_pin), .pwm_pin_oe(pwm_pin_oe),
	.ovf_irq(ovf_irq), .capture_irq(capture_irq), .wake_req(wake_req));
`default_nettype wire
